// ---- shared/csr_res_pkg.sv ----
// Purpose: Constants and types for the bus management resource bank
// Assumes: 32-bit AXI4-Lite register window, byte offsets
// Notes: Serial bus addresses are 48-bit offsets in the node space
package csr_res_pkg;
  // Register byte offsets on the host bus
  localparam logic [7:0] OFS_NEW = 8'h00;
  localparam logic [7:0] OFS_CMP = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_HDR = 8'h0c;
  localparam logic [7:0] OFS_IDENT = 8'h10;
  localparam logic [7:0] OFS_OPT = 8'h14;
  localparam logic [7:0] OFS_GID_HI = 8'h18;
  localparam logic [7:0] OFS_GID_LO = 8'h1c;
  localparam logic [7:0] OFS_CCTL = 8'h20;
  // Field positions
  localparam int DONE_BIT = 31;
  localparam int LINK_BIT = 0;
  localparam int MAXREC_LSB = 12;
  // Serial bus addresses of the served quadlets
  localparam logic [47:0] ADR_BM_ID = 48'hffff_f000_021c;
  localparam logic [47:0] ADR_BW = 48'hffff_f000_0220;
  localparam logic [47:0] ADR_CH_HI = 48'hffff_f000_0224;
  localparam logic [47:0] ADR_CH_LO = 48'hffff_f000_0228;
  localparam logic [47:0] ADR_HDR = 48'hffff_f000_0400;
  localparam logic [47:0] ADR_IDENT = 48'hffff_f000_0404;
  localparam logic [47:0] ADR_OPT = 48'hffff_f000_0408;
  localparam logic [47:0] ADR_GID_HI = 48'hffff_f000_040c;
  localparam logic [47:0] ADR_GID_LO = 48'hffff_f000_0410;
  // Values after reset
  localparam logic [31:0] RST_BM_ID = 32'h0000_003f;
  localparam logic [31:0] RST_BW = 32'h0000_1333;
  localparam logic [31:0] RST_CH = 32'hffff_ffff;
  localparam logic [31:0] RST_HDR = 32'h0404_0000;
  localparam logic [31:0] BUS_IDENT = 32'h3133_3934;
  // Resource selector codes
  typedef enum logic [1:0] {
    SEL_BM_ID = 2'b00,
    SEL_BW = 2'b01,
    SEL_CH_HI = 2'b10,
    SEL_CH_LO = 2'b11
  } res_sel_t;
  // Remote request from the link side
  typedef struct packed {
    logic is_lock;
    logic [47:0] addr;
    logic [31:0] cmp;
    logic [31:0] data;
  } rmt_req_t;
  // Remote answer
  typedef struct packed {
    logic ok;
    logic [31:0] data;
  } rmt_rsp_t;
endpackage : csr_res_pkg

// ---- rtl/csr_res_bank.sv ----
// Purpose: Swap resources, ROM header and bus info block quadlets
// Assumes: clk_i 100 MHz, sys_rst_i is the hardware reset
// Notes: Remote requests come from the link's receive path
//
// What this block does
// - Upper channels at 0224, selector 2, ones
// - Lower channels at 0228, selector 3, ones
// - Manager ID 3F sel 0, bandwidth 1333 sel 1
// - Remote lock requests finish in hardware
// - Control selector picks one of four resources
// - Store only when current equals expected
// - Control write starts a swap
// - Complete flag: one at reset, cleared, set
// - Old value lands in new-value register
// - Resources never written directly
// - Header served as first ROM quadlet
// - Header lengths reset to 4, CRC from ROM
// - Read-only bus ident 31333934
// - Options served as second info quadlet
// - Oversized block writes flag type error
// - Reserved option bits stay read/write
// - Unique ID served as third, fourth quadlets
// - Unique ID zero on hardware reset only
// - Unique ID loaded once per hardware reset
// - Unique ID read-only after loading
`timescale 1ns/10ps
`default_nettype none
module csr_res_bank
  import csr_res_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic soft_rst_i,
  input wire logic bus_reset_i,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Remote quadlet read and lock requests
  input wire rmt_req_t rmt_req_i,
  input wire logic rmt_valid_i,
  output logic rmt_ready_o,
  output rmt_rsp_t rmt_rsp_o,
  output logic rmt_rvalid_o,
  // Received block write length check
  input wire logic [15:0] blk_len_i,
  output logic type_err_o,
  // Unique-ID ROM autoload and link enable
  input wire logic rom_load_i,
  input wire logic [31:0] rom_gid_hi_i,
  input wire logic [31:0] rom_gid_lo_i,
  input wire logic [15:0] rom_crc_i,
  output logic link_on_o
);

  // Byte-lane merge for register writes
  function automatic logic [31:0] merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // Host offset decode, one bit: true for the nine aligned offsets up to OFS_CCTL
  function automatic logic mapped(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= OFS_CCTL);
  endfunction : mapped

  // Serial bus address to local code: 0-3 resource, 4-8 info, 15 none
  function automatic logic [3:0] rdec(input logic [47:0] a);
    unique case (a)
      ADR_BM_ID: return 4'h0;
      ADR_BW: return 4'h1;
      ADR_CH_HI: return 4'h2;
      ADR_CH_LO: return 4'h3;
      ADR_HDR: return 4'h4;
      ADR_IDENT: return 4'h5;
      ADR_OPT: return 4'h6;
      ADR_GID_HI: return 4'h7;
      ADR_GID_LO: return 4'h8;
      default: return 4'hf;
    endcase
  endfunction : rdec

  // Storage
  logic [31:0] res_reg [4]; // Four swap resources
  logic [31:0] new_reg; // New value, later old value
  logic [31:0] cmp_reg; // Expected value
  res_sel_t sel_reg; // Resource selector
  logic done_reg; // Swap complete
  logic pend_reg; // Host swap waiting to run
  logic [31:0] hdr_reg; // ROM header quadlet
  logic [31:0] opt_reg; // Bus option quadlet
  logic [31:0] gid_hi_reg;
  logic [31:0] gid_lo_reg;
  logic gid_hi_lk; // High word loaded
  logic gid_lo_lk; // Low word loaded
  logic link_reg;
  logic any_rst; // Hardware or software reset
  // Bus side
  logic aw_have, w_have;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg, rvalid_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;
  logic wr_fire, rd_fire;
  logic [31:0] host_cur; // Selected resource now
  logic host_hit; // Host compare matches
  logic rmt_go; // Remote request taken
  logic [3:0] rmt_code;
  logic [31:0] rmt_cur;
  logic rmt_hit;
  rmt_rsp_t rsp_reg;
  logic rsp_v_reg;
  logic terr_reg;

  assign any_rst = sys_rst_i | soft_rst_i;

  // Write channel handshakes; address and data taken in either order
  assign s_axi_awready_o = !aw_have;
  assign s_axi_wready_o = !w_have;
  assign wr_fire = aw_have & w_have & !bvalid_reg;
  assign s_axi_bvalid_o = bvalid_reg;
  assign s_axi_bresp_o = bresp_reg;

  // Capture write address and data, release both at the write
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else begin
      if (s_axi_awvalid_i && !aw_have) begin
        aw_have <= 1'b1;
        awaddr_reg <= s_axi_awaddr_i;
      end else if (wr_fire) begin
        aw_have <= 1'b0;
      end
      if (s_axi_wvalid_i && !w_have) begin
        w_have <= 1'b1;
        wdata_reg <= s_axi_wdata_i;
        wstrb_reg <= s_axi_wstrb_i;
      end else if (wr_fire) begin
        w_have <= 1'b0;
      end
    end
  end

  // Write response; unmapped offsets answer SLVERR
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'b00;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= mapped(awaddr_reg) ? 2'b00 : 2'b10;
    end else if (s_axi_bready_i) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Host-side swap engine
  assign host_cur = res_reg[sel_reg];
  assign host_hit = (host_cur == cmp_reg);

  // Expected value register
  always_ff @(posedge clk_i) begin
    if (any_rst) begin
      cmp_reg <= 32'h0000_0000;
    end else if (wr_fire && awaddr_reg == OFS_CMP) begin
      cmp_reg <= merge(cmp_reg, wdata_reg, wstrb_reg);
    end
  end

  // New value register; a finishing swap wins over a host write
  always_ff @(posedge clk_i) begin
    if (any_rst) begin
      new_reg <= 32'h0000_0000;
    end else if (pend_reg) begin
      new_reg <= host_cur;
    end else if (wr_fire && awaddr_reg == OFS_NEW) begin
      new_reg <= merge(new_reg, wdata_reg, wstrb_reg);
    end
  end

  // Control: selector, pending swap and completion flag
  always_ff @(posedge clk_i) begin
    if (any_rst) begin
      sel_reg <= SEL_BM_ID;
      pend_reg <= 1'b0;
      done_reg <= 1'b1;
    end else begin
      if (wr_fire && awaddr_reg == OFS_CTRL) begin
        if (wstrb_reg[0]) begin
          sel_reg <= res_sel_t'(wdata_reg[1:0]);
        end
        pend_reg <= 1'b1;
      end else if (pend_reg) begin
        pend_reg <= 1'b0;
      end
      // Completion set wins over the clear from a control write
      if (pend_reg) begin
        done_reg <= 1'b1;
      end else if (wr_fire && awaddr_reg == OFS_CTRL) begin
        done_reg <= 1'b0;
      end
    end
  end

  // Remote path; stalled while a host swap waits so the two never mix
  assign rmt_ready_o = !pend_reg;
  assign rmt_go = rmt_valid_i & rmt_ready_o;
  assign rmt_code = rdec(rmt_req_i.addr);
  assign rmt_cur = res_reg[rmt_code[1:0]];
  assign rmt_hit = (rmt_cur == rmt_req_i.cmp);

  // Resources change only by compare-and-swap or reset
  always_ff @(posedge clk_i) begin
    if (any_rst || bus_reset_i) begin
      res_reg[SEL_BM_ID] <= RST_BM_ID;
      res_reg[SEL_BW] <= RST_BW;
      res_reg[SEL_CH_HI] <= RST_CH;
      res_reg[SEL_CH_LO] <= RST_CH;
    end else if (pend_reg) begin
      if (host_hit) begin
        res_reg[sel_reg] <= new_reg;
      end
    end else if (rmt_go && rmt_req_i.is_lock && !rmt_code[3]) begin
      if (rmt_code[2] == 1'b0 && rmt_hit) begin
        res_reg[rmt_code[1:0]] <= rmt_req_i.data;
      end
    end
  end

  // Remote answer one cycle after the request is taken
  always_ff @(posedge clk_i) begin
    if (any_rst) begin
      rsp_reg <= '0;
      rsp_v_reg <= 1'b0;
    end else begin
      rsp_v_reg <= rmt_go;
      if (rmt_go) begin
        rsp_reg.ok <= rmt_req_i.is_lock ? (rmt_code < 4'h4)
                                        : (rmt_code != 4'hf);
        unique case (rmt_code)
          4'h0, 4'h1, 4'h2, 4'h3: rsp_reg.data <= rmt_cur;
          4'h4: rsp_reg.data <= hdr_reg;
          4'h5: rsp_reg.data <= BUS_IDENT;
          4'h6: rsp_reg.data <= opt_reg;
          4'h7: rsp_reg.data <= gid_hi_reg;
          4'h8: rsp_reg.data <= gid_lo_reg;
          default: rsp_reg.data <= 32'h0000_0000;
        endcase
      end
    end
  end
  assign rmt_rsp_o = rsp_reg;
  assign rmt_rvalid_o = rsp_v_reg;

  // ROM header; the CRC field follows the ROM when one loads
  always_ff @(posedge clk_i) begin
    if (any_rst) begin
      hdr_reg <= RST_HDR;
    end else if (rom_load_i && !gid_hi_lk && !gid_lo_lk) begin
      hdr_reg[15:0] <= rom_crc_i;
    end else if (wr_fire && awaddr_reg == OFS_HDR) begin
      hdr_reg <= merge(hdr_reg, wdata_reg, wstrb_reg);
    end
  end

  // Bus options, reserved bits kept as plain storage
  always_ff @(posedge clk_i) begin
    if (any_rst) begin
      opt_reg <= 32'h0000_0000;
    end else if (wr_fire && awaddr_reg == OFS_OPT) begin
      opt_reg <= merge(opt_reg, wdata_reg, wstrb_reg);
    end
  end

  // Block write length check; limit is 2^(max_rec+1) bytes
  always_ff @(posedge clk_i) begin
    if (any_rst) begin
      terr_reg <= 1'b0;
    end else begin
      terr_reg <= ({1'b0, blk_len_i} >
        (17'h1_0000 >> (5'd15 - {1'b0,
         opt_reg[MAXREC_LSB +: 4]})));
    end
  end
  assign type_err_o = terr_reg;

  // Unique ID: cleared only by hardware reset, then written once
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      gid_hi_reg <= 32'h0000_0000;
      gid_lo_reg <= 32'h0000_0000;
      gid_hi_lk <= 1'b0;
      gid_lo_lk <= 1'b0;
    end else if (rom_load_i && !gid_hi_lk && !gid_lo_lk) begin
      gid_hi_reg <= rom_gid_hi_i;
      gid_lo_reg <= rom_gid_lo_i;
      gid_hi_lk <= 1'b1;
      gid_lo_lk <= 1'b1;
    end else if (wr_fire) begin
      // A firmware write locks its word even with partial strobes
      if (awaddr_reg == OFS_GID_HI && !gid_hi_lk) begin
        gid_hi_reg <= merge(gid_hi_reg, wdata_reg, wstrb_reg);
        gid_hi_lk <= 1'b1;
      end
      if (awaddr_reg == OFS_GID_LO && !gid_lo_lk) begin
        gid_lo_reg <= merge(gid_lo_reg, wdata_reg, wstrb_reg);
        gid_lo_lk <= 1'b1;
      end
    end
  end

  // Link enable; hardware does not police the unique ID order
  always_ff @(posedge clk_i) begin
    if (any_rst) begin
      link_reg <= 1'b0;
    end else if (wr_fire && awaddr_reg == OFS_CCTL && wstrb_reg[0]) begin
      link_reg <= wdata_reg[LINK_BIT];
    end
  end
  assign link_on_o = link_reg;

  // Read channel; one read in flight, data from flip-flops
  assign s_axi_arready_o = !rvalid_reg;
  assign rd_fire = s_axi_arvalid_i & !rvalid_reg;
  assign s_axi_rvalid_o = rvalid_reg;
  assign s_axi_rdata_o = rdata_reg;
  assign s_axi_rresp_o = rresp_reg;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= 2'b00;
    end else if (rd_fire) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= mapped(s_axi_araddr_i) ? 2'b00 : 2'b10;
      unique case (s_axi_araddr_i)
        OFS_NEW: rdata_reg <= new_reg;
        OFS_CMP: rdata_reg <= cmp_reg;
        OFS_CTRL: rdata_reg <= {done_reg, 29'h0, sel_reg};
        OFS_HDR: rdata_reg <= hdr_reg;
        OFS_IDENT: rdata_reg <= BUS_IDENT;
        OFS_OPT: rdata_reg <= opt_reg;
        OFS_GID_HI: rdata_reg <= gid_hi_reg;
        OFS_GID_LO: rdata_reg <= gid_lo_reg;
        OFS_CCTL: rdata_reg <= {31'h0, link_reg};
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready_i) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i || soft_rst_i);

  logic ctrl_wr;
  assign ctrl_wr = wr_fire && awaddr_reg == OFS_CTRL;

  a_swap_done_time: assert property (
    ctrl_wr && !pend_reg |=> !done_reg ##1 done_reg)
    else $error("swap completion timing wrong");
  a_swap_starts: assert property (
    ctrl_wr |=> pend_reg && !rmt_ready_o)
    else $error("control write did not start swap");
  a_swap_store: assert property (
    pend_reg && !bus_reset_i |=>
      (res_reg[$past(sel_reg)] == ($past(host_hit) ?
       $past(new_reg) : $past(host_cur))))
    else $error("resource store wrong");
  a_old_value: assert property (
    pend_reg |=> new_reg == $past(host_cur))
    else $error("old value not returned");
  a_chan_reset: assert property (
    bus_reset_i |=> res_reg[2] == RST_CH && res_reg[3] == RST_CH)
    else $error("channel reset wrong");
  a_bm_reset: assert property (
    bus_reset_i |=> res_reg[0] == RST_BM_ID && res_reg[1] == RST_BW)
    else $error("manager or bandwidth reset wrong");
  a_gid_frozen: assert property (
    gid_hi_lk && gid_lo_lk |=> $stable(gid_hi_reg) && $stable(gid_lo_reg))
    else $error("unique id changed after load");
  a_rmt_ident: assert property (
    rmt_go && rmt_req_i.addr == ADR_IDENT && !rmt_req_i.is_lock
      |=> rmt_rvalid_o && rmt_rsp_o.data == BUS_IDENT)
    else $error("bus ident served wrong");
  // A taken remote lock that matches must land intact, untouched by a swap
  a_no_interleave: assert property (
    rmt_go && rmt_req_i.is_lock && rmt_code < 4'h4 && rmt_hit &&
      !bus_reset_i |=>
      res_reg[$past(rmt_code[1:0])] == $past(rmt_req_i.data))
    else $error("remote lock store interleaved");

  c_host_swap: cover property (pend_reg && host_hit);
  c_rmt_lock: cover property (rmt_go && rmt_req_i.is_lock && rmt_hit);
  c_rom_load: cover property (rom_load_i && !gid_hi_lk ##1 gid_lo_lk);

endmodule : csr_res_bank
`default_nettype wire

// ---- test/rmt_node.sv ----
// Purpose: Remote node model issuing quadlet reads and locks
// Assumes: Request held until taken; answer is a one-cycle pulse
// Notes: Payload is inverted once released, so stale data never matches
`timescale 1ns/10ps
`default_nettype none
module rmt_node
  import csr_res_pkg::*;
(
  input wire logic clk_i,
  output rmt_req_t req_o,
  output logic valid_o,
  input wire logic ready_i,
  input wire rmt_rsp_t rsp_i,
  input wire logic rvalid_i
);
  // Idle at time zero
  initial begin
    req_o = '0;
    valid_o = 1'b0;
  end
  // One request after an optional stall; tmo stays high on a hang
  task automatic xfer(input logic lk, input logic [47:0] a,
                      input logic [31:0] c, input logic [31:0] d,
                      input int stall, output rmt_rsp_t rsp,
                      output logic tmo);
    int n;
    logic t;
    tmo = 1'b1;
    repeat (stall + 1) @(posedge clk_i);
    req_o <= '{lk, a, c, d};
    valid_o <= 1'b1;
    // Ready only changes on edges, so the falling edge sees its value
    for (n = 0; n < 40; n++) begin
      @(negedge clk_i);
      t = ready_i;
      @(posedge clk_i);
      if (t) break;
    end
    valid_o <= 1'b0;
    req_o <= ~req_o;
    for (n = 0; n < 40; n++) begin
      @(negedge clk_i);
      if (rvalid_i) begin
        rsp = rsp_i;
        tmo = 1'b0;
        break;
      end
    end
    @(posedge clk_i);
  endtask : xfer
endmodule : rmt_node
`default_nettype wire

// ---- test/test_bus_mgmt_csr_and_bus_info_regs.sv ----
// Purpose: Self-checking bench for the resource bank
// Assumes: Master tasks sample handshakes at the falling edge
// Notes: Resource model res_m is updated per swap from the rules
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, a) begin \
  tests_run++; \
  if ((a) !== (e)) begin \
    err_total++; \
    $display("[ERR] %s exp %h got %h", nm, e, a); \
  end \
end
module test_bus_mgmt_csr_and_bus_info_regs import csr_res_pkg::*;;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic soft_rst_i = 1'b0;
  logic bus_reset_i = 1'b0;
  logic rom_load = 1'b0;
  logic [7:0] awaddr = '0;
  logic [7:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [15:0] blk_len = '0;
  logic [31:0] rom_hi = '0;
  logic [31:0] rom_lo = '0;
  logic [15:0] rom_crc = '0;
  wire logic awready, wready, bvalid, arready, rvalid, rr, rvo, terr;
  wire logic rv, link_on;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire rmt_req_t req;
  wire rmt_rsp_t rsp;
  int err_total = 0;
  int tests_run = 0;
  int k;
  logic [31:0] rdq, v, g, cv, nv, ev;
  logic [1:0] bq, rrq, s;
  rmt_rsp_t rsp_q;
  logic [31:0] res_m [4];
  logic [31:0] msk [4];
  logic [47:0] radr [4];

  always #5 clk_i = ~clk_i;

  csr_res_bank csr_res_bank_i (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .soft_rst_i(soft_rst_i),
    .bus_reset_i(bus_reset_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .rmt_req_i(req), .rmt_valid_i(rv), .rmt_ready_o(rr),
    .rmt_rsp_o(rsp), .rmt_rvalid_o(rvo), .blk_len_i(blk_len),
    .type_err_o(terr), .rom_load_i(rom_load), .rom_gid_hi_i(rom_hi),
    .rom_gid_lo_i(rom_lo), .rom_crc_i(rom_crc), .link_on_o(link_on)
  );
  rmt_node rmt_node_i (
    .clk_i(clk_i), .req_o(req), .valid_o(rv), .ready_i(rr),
    .rsp_i(rsp), .rvalid_i(rvo)
  );

  // Verdict and end of run; also reached by any timeout
  task automatic wrap_up;
    if (err_total == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up

  // Write with address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] sb = 4'hf);
    int n;
    logic ta, tw, tb;
    @(posedge clk_i);
    awaddr <= a;
    wdata <= d;
    wstrb <= sb;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(negedge clk_i);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      bq = bresp;
      @(posedge clk_i);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) break;
    end
    bready <= 1'b0;
    if (n == 40) begin
      err_total++;
      wrap_up();
    end
  endtask : wr

  // Read; data and response land in rdq and rrq
  task automatic rd(input logic [7:0] a);
    int n;
    logic ta, tr;
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(negedge clk_i);
      ta = arvalid && arready;
      tr = rvalid;
      rdq = rdata;
      rrq = rresp;
      @(posedge clk_i);
      if (ta) arvalid <= 1'b0;
      if (tr) break;
    end
    rready <= 1'b0;
    if (n == 40) begin
      err_total++;
      wrap_up();
    end
  endtask : rd

  // Remote request through the partner model
  task automatic rmt(input logic lk, input logic [47:0] a,
                     input logic [31:0] c, input logic [31:0] d,
                     input int st);
    logic tmo;
    rmt_node_i.xfer(lk, a, c, d, st, rsp_q, tmo);
    if (tmo) begin
      err_total++;
      wrap_up();
    end
  endtask : rmt

  // One-cycle pulse on one of the reset or load inputs
  task automatic pulse(input int w);
    @(posedge clk_i);
    case (w)
      0: soft_rst_i <= 1'b1;
      1: bus_reset_i <= 1'b1;
      2: sys_rst_i <= 1'b1;
      default: rom_load <= 1'b1;
    endcase
    @(posedge clk_i);
    soft_rst_i <= 1'b0;
    bus_reset_i <= 1'b0;
    sys_rst_i <= 1'b0;
    rom_load <= 1'b0;
  endtask : pulse

  // Model reset values, then read every resource from the remote side
  task automatic chk_res;
    res_m = '{RST_BM_ID, RST_BW, RST_CH, RST_CH};
    for (int i = 0; i < 4; i++) begin
      rmt(1'b0, radr[i], '0, '0, i);
      `CHK("res", res_m[i], rsp_q.data)
    end
  endtask : chk_res

  initial begin
    void'($urandom(4));
    radr = '{ADR_BM_ID, ADR_BW, ADR_CH_HI, ADR_CH_LO};
    // Narrow resources only get values that fit their fields
    msk = '{32'h0000_003f, 32'h0000_1fff, 32'hffff_ffff, 32'hffff_ffff};
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    chk_res();
    rd(OFS_CTRL);
    `CHK("done0", 1'b1, rdq[DONE_BIT])
    rd(OFS_HDR);
    `CHK("hdr", 16'h0404, rdq[31:16])
    wr(OFS_IDENT, $urandom);
    rd(OFS_IDENT);
    `CHK("ident", BUS_IDENT, rdq)
    rd(OFS_GID_HI);
    `CHK("gid0", 32'h0, rdq)
    wr(8'h24, $urandom);
    `CHK("bresp", 2'b10, bq)
    rd(8'h24);
    `CHK("rresp", 2'b10, rrq)
    // Host swaps: first pass compares equal, second pass never does
    for (k = 0; k < 8; k++) begin
      s = k[1:0];
      nv = $urandom & msk[s];
      cv = (k < 4) ? res_m[s] : ~res_m[s];
      wr(OFS_NEW, nv);
      wr(OFS_CMP, cv);
      wr(OFS_CTRL, {30'h0, s});
      rd(OFS_CTRL);
      `CHK("ctrl", {1'b1, s}, {rdq[31], rdq[1:0]})
      rd(OFS_NEW);
      `CHK("old", res_m[s], rdq)
      if (cv == res_m[s]) res_m[s] = nv;
      rmt(1'b0, radr[s], '0, '0, 0);
      `CHK("res", res_m[s], rsp_q.data)
    end
    // Remote locks, prompt and stalled, back to back
    for (k = 0; k < 8; k++) begin
      s = k[1:0];
      nv = $urandom & msk[s];
      cv = (k < 4) ? res_m[s] : ~res_m[s];
      rmt(1'b1, radr[s], cv, nv, k % 3);
      `CHK("rok", 1'b1, rsp_q.ok)
      `CHK("rold", res_m[s], rsp_q.data)
      if (cv == res_m[s]) res_m[s] = nv;
    end
    rmt(1'b1, ADR_HDR, '0, '0, 0);
    `CHK("rbad", 1'b0, rsp_q.ok)
    // Host and remote swap race on one resource; only one may win
    cv = res_m[2];
    v = $urandom;
    nv = $urandom;
    wr(OFS_NEW, v);
    wr(OFS_CMP, cv);
    fork
      wr(OFS_CTRL, 32'h2);
      rmt(1'b1, radr[2], cv, nv, 2);
    join
    if (rsp_q.data === cv) begin
      res_m[2] = nv;
      ev = nv;
    end else begin
      res_m[2] = v;
      ev = cv;
      `CHK("race", v, rsp_q.data)
    end
    rd(OFS_NEW);
    `CHK("racenew", ev, rdq)
    rmt(1'b0, radr[2], '0, '0, 1);
    `CHK("raceres", res_m[2], rsp_q.data)
    pulse(1);
    chk_res();
    // Option and header quadlets
    v = $urandom;
    wr(OFS_OPT, v);
    rd(OFS_OPT);
    `CHK("opt", v, rdq)
    wr(OFS_OPT, 32'h0, 4'h1);
    v[7:0] = 8'h00;
    rd(OFS_OPT);
    `CHK("optb", v, rdq)
    rmt(1'b0, ADR_OPT, '0, '0, 0);
    `CHK("ropt", v, rsp_q.data)
    v = $urandom;
    wr(OFS_HDR, v);
    rmt(1'b0, ADR_HDR, '0, '0, 2);
    `CHK("rhdr", v, rsp_q.data)
    rmt(1'b0, ADR_IDENT, '0, '0, 0);
    `CHK("rident", BUS_IDENT, rsp_q.data)
    // Limit of 16 bytes: 16 passes, 17 is flagged
    wr(OFS_OPT, 32'h0000_3000);
    for (k = 0; k < 2; k++) begin
      @(posedge clk_i);
      blk_len <= 16'd16 + 16'(k);
      @(posedge clk_i);
      @(negedge clk_i);
      `CHK("terr", k[0], terr)
    end
    // Firmware load of the unique ID, then lock
    g = $urandom | 32'h1;
    wr(OFS_GID_HI, g);
    wr(OFS_GID_HI, ~g);
    rd(OFS_GID_HI);
    `CHK("gidhi", g, rdq)
    wr(OFS_GID_LO, ~g);
    rmt(1'b0, ADR_GID_LO, '0, '0, 0);
    `CHK("rgidlo", ~g, rsp_q.data)
    rmt(1'b0, ADR_GID_HI, '0, '0, 0);
    `CHK("rgidhi", g, rsp_q.data)
    wr(OFS_CCTL, 32'h1);
    rd(OFS_CCTL);
    `CHK("link", 1'b1, link_on)
    `CHK("linkrd", 32'h1, rdq)
    pulse(0);
    rom_hi <= ~g;
    pulse(3);
    `CHK("linkoff", 1'b0, link_on)
    rd(OFS_GID_HI);
    `CHK("gidsoft", g, rdq)
    // Hardware reset clears the ID; ROM load fills it and the CRC
    pulse(2);
    rd(OFS_GID_LO);
    `CHK("gidhw", 32'h0, rdq)
    rom_hi <= $urandom | 32'h1;
    rom_lo <= $urandom;
    rom_crc <= 16'($urandom);
    pulse(3);
    rd(OFS_GID_HI);
    `CHK("romhi", rom_hi, rdq)
    rd(OFS_GID_LO);
    `CHK("romlo", rom_lo, rdq)
    rd(OFS_HDR);
    `CHK("romcrc", {16'h0404, rom_crc}, rdq)
    wr(OFS_GID_HI, ~rom_hi);
    rd(OFS_GID_HI);
    `CHK("romlock", rom_hi, rdq)
    wrap_up();
  end
endmodule : test_bus_mgmt_csr_and_bus_info_regs
`default_nettype wire
